// *** core/capture_flag_status.sv ***
// Input capture flags of a 16-bit free-running timer with a Wishbone register port
//
// Notes on behaviour
// - Reset clears the whole control/status register, so all four flags start at zero.
// - A channel A capture loads the counter into capture register A and sets flag A.
// - A channel B capture loads the counter into capture register B and sets flag B.
// - Buffer mode A: capture A moves old A into C, loads A, sets flag A.
// - Buffer mode B: capture B moves old B into D, loads B, sets flag B.
// - Without buffer mode A, a channel C capture loads register C and sets flag C.
// - Without buffer mode B, a channel D capture loads register D and sets flag D.
// - Buffer mode A: a pin C edge sets flag C but leaves register C alone.
// - Buffer mode B: a pin D edge sets flag D but leaves register D alone.
// - Buffered: flag C with its enable forms an external interrupt from pin C.
// - Buffered: flag D with its enable forms an external interrupt from pin D.
// - A flag clears only after it was read as one and then written zero.
// - Writing one to a flag bit does nothing.
// - A flag requests an interrupt only while its enable bit is one.
// - With counter clear selected, a match with compare register A clears the counter.
//
// The address map and the Wishbone slave port were left to the implementer.

`include "capture_flag_status_cfg.svh"

module capture_flag_status (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    cyc_i,
	input  wire logic                    stb_i,
	input  wire logic                    we_i,
	input  wire logic [`CFS_ADR_W-1:0]   adr_i,
	input  wire logic [`CFS_SEL_W-1:0]   sel_i,
	input  wire logic [`CFS_DATA_W-1:0]  dat_i,
	output logic      [`CFS_DATA_W-1:0]  dat_o,
	output logic                         ack_o,
	input  wire logic                    capture_pin_a_i,
	input  wire logic                    capture_pin_b_i,
	input  wire logic                    capture_pin_c_i,
	input  wire logic                    capture_pin_d_i,
	output capture_flag_status_pkg::count_t free_running_counter_o,
	output logic      [`CFS_CHAN_N-1:0]  capture_flag_o,
	output logic                         irq_o
);
	import capture_flag_status_pkg::*;

	state_t                  s;
	state_t                  next_s;
	logic [`CFS_CHAN_N-1:0]  pins;
	logic [`CFS_CHAN_N-1:0]  hit;
	logic [`CFS_CHAN_N-1:0]  clr;
	logic                    match_a;
	logic                    start;
	logic                    commit;

	// True when the selected edge appears; sel one means rising, zero falling
	function automatic logic edge_hit(input logic prev, input logic cur, input logic sel);
		edge_hit = sel ? (~prev & cur) : (prev & ~cur);
	endfunction

	// Byte-lane merge of a 16-bit register
	function automatic count_t merge16(input count_t old, input logic [`CFS_DATA_W-1:0] d,
			input logic [`CFS_SEL_W-1:0] sel);
		count_t r;
		r = old;
		if (sel[`CFS_LANE_LO]) begin
			r[7:0] = d[7:0];
		end
		if (sel[`CFS_LANE_HI]) begin
			r[15:8] = d[15:8];
		end
		merge16 = r;
	endfunction

	// Read multiplexer; unmapped words read as zero
	function automatic logic [`CFS_DATA_W-1:0] read_word(input state_t st,
			input logic [`CFS_ADR_W-1:0] a);
		logic [`CFS_DATA_W-1:0] w;
		w = '0;
		case (a)
			`CFS_ADR_CONTROL_STATUS: begin
				w[`CFS_FLAG_MSB:`CFS_FLAG_LSB] = st.flags;
				w[`CFS_CCLR_BIT] = st.clear_on_match;
			end
			`CFS_ADR_TIMER_CONTROL: begin
				w[`CFS_EDGE_MSB:`CFS_EDGE_LSB] = st.edge_sel;
				w[`CFS_BUFA_BIT] = st.buf_a;
				w[`CFS_BUFB_BIT] = st.buf_b;
			end
			`CFS_ADR_IRQ_ENABLE: w[`CFS_IEN_MSB:`CFS_IEN_LSB] = st.irq_en;
			`CFS_ADR_CAPTURE_A: w[`CFS_COUNT_W-1:0] = st.capture[`CFS_CH_A];
			`CFS_ADR_CAPTURE_B: w[`CFS_COUNT_W-1:0] = st.capture[`CFS_CH_B];
			`CFS_ADR_CAPTURE_C: w[`CFS_COUNT_W-1:0] = st.capture[`CFS_CH_C];
			`CFS_ADR_CAPTURE_D: w[`CFS_COUNT_W-1:0] = st.capture[`CFS_CH_D];
			`CFS_ADR_COUNTER: w[`CFS_COUNT_W-1:0] = st.counter;
			`CFS_ADR_COMPARE_A: w[`CFS_COUNT_W-1:0] = st.compare_a;
			default: w = '0;
		endcase
		read_word = w;
	endfunction

	// Pins gathered in channel order, A at the top
	assign pins = {capture_pin_a_i, capture_pin_b_i, capture_pin_c_i, capture_pin_d_i};

	// Request taken on the first edge, committed on the edge where ack is seen
	assign start  = cyc_i & stb_i & (s.phase == BUS_IDLE);
	assign commit = cyc_i & stb_i & (s.phase == BUS_ANSWER);
	assign match_a = (s.counter == s.compare_a);

	// Edge detection against the previous pin sample
	always_comb begin
		for (int i = 0; i < `CFS_CHAN_N; i++) begin
			hit[i] = edge_hit(s.pin_q[i], pins[i], s.edge_sel[i]);
		end
	end

	// Flags armed by a read of one and then written zero are cleared
	always_comb begin
		clr = '0;
		if (commit && we_i && sel_i[`CFS_LANE_LO]
				&& adr_i == `CFS_ADR_CONTROL_STATUS) begin
			clr = s.armed & ~dat_i[`CFS_FLAG_MSB:`CFS_FLAG_LSB];
		end
	end

	// Next state of the whole block
	always_comb begin
		next_s = s;
		next_s.pin_q = pins;

		// Counter runs every clock, cleared on compare match when selected
		if (match_a && s.clear_on_match) begin
			next_s.counter = `CFS_CNT_ZERO;
		end else begin
			next_s.counter = s.counter + `CFS_CNT_ONE;
		end

		// Channel A capture, with shift into C in buffer mode
		if (hit[`CFS_CH_A]) begin
			if (s.buf_a) begin
				next_s.capture[`CFS_CH_C] = s.capture[`CFS_CH_A];
			end
			next_s.capture[`CFS_CH_A] = s.counter;
		end

		// Channel B capture, with shift into D in buffer mode
		if (hit[`CFS_CH_B]) begin
			if (s.buf_b) begin
				next_s.capture[`CFS_CH_D] = s.capture[`CFS_CH_B];
			end
			next_s.capture[`CFS_CH_B] = s.counter;
		end

		// Channel C loads only outside buffer mode A
		if (hit[`CFS_CH_C] && !s.buf_a) begin
			next_s.capture[`CFS_CH_C] = s.counter;
		end

		// Channel D loads only outside buffer mode B
		if (hit[`CFS_CH_D] && !s.buf_b) begin
			next_s.capture[`CFS_CH_D] = s.counter;
		end

		// Every selected edge sets its flag, and the set wins over the clear
		next_s.flags = (s.flags & ~clr) | hit;

		// Bus handshake and register writes
		if (start) begin
			next_s.phase = BUS_ANSWER;
			next_s.ack   = 1'b1;
			next_s.dat   = read_word(s, adr_i);
		end else if (commit) begin
			next_s.phase = BUS_IDLE;
			next_s.ack   = 1'b0;
			if (we_i) begin
				case (adr_i)
					`CFS_ADR_CONTROL_STATUS: begin
						if (sel_i[`CFS_LANE_LO]) begin
							next_s.armed = '0;
							next_s.clear_on_match = dat_i[`CFS_CCLR_BIT];
						end
					end
					`CFS_ADR_TIMER_CONTROL: begin
						if (sel_i[`CFS_LANE_LO]) begin
							next_s.edge_sel = dat_i[`CFS_EDGE_MSB:`CFS_EDGE_LSB];
							next_s.buf_a    = dat_i[`CFS_BUFA_BIT];
							next_s.buf_b    = dat_i[`CFS_BUFB_BIT];
						end
					end
					`CFS_ADR_IRQ_ENABLE: begin
						if (sel_i[`CFS_LANE_LO]) begin
							next_s.irq_en = dat_i[`CFS_IEN_MSB:`CFS_IEN_LSB];
						end
					end
					`CFS_ADR_COMPARE_A: next_s.compare_a = merge16(s.compare_a, dat_i, sel_i);
					default: next_s.compare_a = s.compare_a;
				endcase
			end else if (adr_i == `CFS_ADR_CONTROL_STATUS) begin
				// Remember which flags software has seen as one
				next_s.armed = s.armed | s.dat[`CFS_FLAG_MSB:`CFS_FLAG_LSB];
			end
		end else begin
			next_s.phase = BUS_IDLE; // Abandoned cycle
			next_s.ack   = 1'b0;
		end

		// One level interrupt from every enabled flag, C and D included
		next_s.irq = |(next_s.flags & next_s.irq_en);
	end

	// State register with synchronous reset to all zeros
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign dat_o                  = s.dat;
	assign ack_o                  = s.ack;
	assign free_running_counter_o = s.counter;
	assign capture_flag_o         = s.flags;
	assign irq_o                  = s.irq;

endmodule

// *** core/capture_flag_status_cfg.svh ***
// Register map, field positions, reset values and widths of the capture flag block
`ifndef CAPTURE_FLAG_STATUS_CFG_SVH
`define CAPTURE_FLAG_STATUS_CFG_SVH

// Word index of each register (byte address is four times the index)
`define CFS_ADR_W             4
`define CFS_ADR_CONTROL_STATUS 4'h0
`define CFS_ADR_TIMER_CONTROL 4'h1
`define CFS_ADR_IRQ_ENABLE    4'h2
`define CFS_ADR_CAPTURE_A     4'h3
`define CFS_ADR_CAPTURE_B     4'h4
`define CFS_ADR_CAPTURE_C     4'h5
`define CFS_ADR_CAPTURE_D     4'h6
`define CFS_ADR_COUNTER       4'h7
`define CFS_ADR_COMPARE_A     4'h8

// Widths
`define CFS_DATA_W            32
`define CFS_SEL_W             4
`define CFS_COUNT_W           16
`define CFS_CHAN_N            4

// Channel index inside four-bit groups: A is the top bit, D the bottom
`define CFS_CH_A              3
`define CFS_CH_B              2
`define CFS_CH_C              1
`define CFS_CH_D              0

// Field positions
`define CFS_FLAG_MSB          7
`define CFS_FLAG_LSB          4
`define CFS_CCLR_BIT          0
`define CFS_EDGE_MSB          7
`define CFS_EDGE_LSB          4
`define CFS_BUFA_BIT          3
`define CFS_BUFB_BIT          2
`define CFS_IEN_MSB           7
`define CFS_IEN_LSB           4
`define CFS_LANE_LO           0
`define CFS_LANE_HI           1

// Reset values and counter constants
`define CFS_CSR_RESET         8'h00
`define CFS_CNT_ZERO          16'h0000
`define CFS_CNT_ONE           16'h0001

`endif

// *** core/capture_flag_status_pkg.sv ***
// Types shared by the capture flag block
`include "capture_flag_status_cfg.svh"

package capture_flag_status_pkg;

	typedef enum logic [0:0] {BUS_IDLE, BUS_ANSWER} bus_phase_t;

	typedef logic [`CFS_COUNT_W-1:0] count_t;

	// Whole state of the block, registered in one place
	typedef struct packed {
		count_t                              counter;
		count_t                              compare_a;
		logic [`CFS_CHAN_N-1:0][`CFS_COUNT_W-1:0] capture;
		logic [`CFS_CHAN_N-1:0]              flags;
		logic [`CFS_CHAN_N-1:0]              armed;
		logic [`CFS_CHAN_N-1:0]              edge_sel;
		logic [`CFS_CHAN_N-1:0]              irq_en;
		logic [`CFS_CHAN_N-1:0]              pin_q;
		logic                                clear_on_match;
		logic                                buf_a;
		logic                                buf_b;
		bus_phase_t                          phase;
		logic                                ack;
		logic [`CFS_DATA_W-1:0]              dat;
		logic                                irq;
	} state_t;

endpackage

// *** test/capture_flag_status_checker.sv ***
// Port-level assertions for the capture flag block
module capture_flag_status_checker (
	input wire logic                           clk_i,
	input wire logic                           rst_i,
	input wire logic                           cyc_i,
	input wire logic                           stb_i,
	input wire logic                           we_i,
	input wire logic [3:0]                     adr_i,
	input wire logic [3:0]                     sel_i,
	input wire logic [31:0]                    dat_i,
	input wire logic [31:0]                    dat_o,
	input wire logic                           ack_o,
	input wire logic                           capture_pin_a_i,
	input wire logic                           capture_pin_b_i,
	input wire logic                           capture_pin_c_i,
	input wire logic                           capture_pin_d_i,
	input wire capture_flag_status_pkg::count_t free_running_counter_o,
	input wire logic [3:0]                     capture_flag_o,
	input wire logic                           irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [3:0] pins;
	logic       clr_wr;
	// Pin group and clearing-write strobe
	assign pins = {capture_pin_a_i, capture_pin_b_i, capture_pin_c_i, capture_pin_d_i};
	assign clr_wr = ack_o && we_i && adr_i == 4'h0;
	// A full pulse on a pin holds one selected edge, unless a clear lands in between
	property pulse_sets(p, f);
		!p ##1 p ##1 (!p && !clr_wr) |=> f;
	endproperty
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	a_reset_zero: assert property (disable iff (1'b0) rst_i |=> capture_flag_o == 4'h0 && !irq_o)
		else $error("flags not cleared by reset");
	a_counter_step: assert property (1'b1 |=> free_running_counter_o ==
		$past(free_running_counter_o) + 16'h0001 || free_running_counter_o == 16'h0000)
		else $error("counter jumped");
	a_clear_cause: assert property (|($past(capture_flag_o) & ~capture_flag_o) |->
		$past(clr_wr && sel_i[0])) else $error("flag fell without a clearing write");
	a_irq_flag: assert property (irq_o |-> capture_flag_o != 4'h0)
		else $error("interrupt without a flag");
	a_pulse_a: assert property (pulse_sets(capture_pin_a_i, capture_flag_o[3]))
		else $error("pulse on pin a left flag a clear");
	a_pulse_b: assert property (pulse_sets(capture_pin_b_i, capture_flag_o[2]))
		else $error("pulse on pin b left flag b clear");
	a_pulse_c: assert property (pulse_sets(capture_pin_c_i, capture_flag_o[1]))
		else $error("pulse on pin c left flag c clear");
	a_pulse_d: assert property (pulse_sets(capture_pin_d_i, capture_flag_o[0]))
		else $error("pulse on pin d left flag d clear");
	a_rise_cause: assert property (!(|(capture_flag_o & ~$past(capture_flag_o)
		& ~($past(pins) ^ $past(pins, 2))))) else $error("flag rose without a pin edge");
	a_unmapped_zero: assert property (ack_o && !we_i && adr_i > 4'h8 |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
	c_irq: cover property (irq_o);
	c_clear: cover property ($fell(capture_flag_o[3]));
	c_wrap: cover property (free_running_counter_o == 16'h0000);
endmodule

// *** test/pin_source.sv ***
// Far side of the capture pins: a register stage, so pins move only after an edge
module pin_source (
	input  wire logic       clk_i,
	input  wire logic [3:0] level_i,
	output logic      [3:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Level requested by the bench reaches the pins one edge later
	always_ff @(posedge clk_i) pin_o <= level_i;
endmodule

// *** test/capture_flag_status_tb.sv ***
// Self-checking bench for the capture flag block with a bus-snooping model
module capture_flag_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
	logic [3:0]  adr_i = 4'h0, sel_i = 4'h0, lv = 4'h0, pins, flag_o, fl, arm, eg, ie, prev;
	logic [31:0] dat_i = 32'h0, dat_o, q;
	logic        ack_o, irq_o, clr, ba, bb, w0;
	logic [15:0] cnt, cmp, free_running_counter, cap [4];
	int          mismatches, checks;
	always #20 clk_i = ~clk_i;
	capture_flag_status DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
		.dat_o, .ack_o, .capture_pin_a_i(pins[3]), .capture_pin_b_i(pins[2]),
		.capture_pin_c_i(pins[1]), .capture_pin_d_i(pins[0]),
		.free_running_counter_o(free_running_counter), .capture_flag_o(flag_o), .irq_o);
	pin_source src (.clk_i, .level_i(lv), .pin_o(pins));
	// Reference model, updated from the bus and pins seen at each rising edge
	always @(posedge clk_i) begin
		w0 = ack_o && we_i && adr_i == 4'h0;
		if (rst_i) begin
			{fl, arm, eg, ie, prev, clr, ba, bb} = '0;
			cnt = 16'h0000;
			cmp = 16'h0000;
			cap = '{default: 16'h0000};
		end else begin
			if (w0 && sel_i[0]) fl &= ~(arm & ~dat_i[7:4]);
			if (ack_o && !we_i && adr_i == 4'h0) arm |= dat_o[7:4];
			for (int k = 0; k < 4; k++)
				if (pins[k] != prev[k] && pins[k] == eg[k]) begin
					fl[k] = 1'b1;
					if (k == 3 && ba) cap[1] = cap[3];
					if (k == 2 && bb) cap[0] = cap[2];
					if (!((k == 1 && ba) || (k == 0 && bb))) cap[k] = cnt;
				end
			prev = pins;
			cnt = (clr && cnt == cmp) ? 16'h0000 : cnt + 16'h0001;
			if (w0 && sel_i[0]) clr = dat_i[0];
			if (w0 && sel_i[0]) arm = 4'h0;
			if (ack_o && we_i && adr_i == 4'h1 && sel_i[0]) {eg, ba, bb} = dat_i[7:2];
			if (ack_o && we_i && adr_i == 4'h2 && sel_i[0]) ie = dat_i[7:4];
			if (ack_o && we_i && adr_i == 4'h8 && sel_i[0]) cmp[7:0] = dat_i[7:0];
			if (ack_o && we_i && adr_i == 4'h8 && sel_i[1]) cmp[15:8] = dat_i[15:8];
		end
	end
	task automatic check(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// Outputs against the model in mid-cycle, once every update has landed
	always @(negedge clk_i) if (!rst_i) begin
		check("flags", flag_o, fl);
		check("irq", irq_o, |(fl & ie));
		check("counter", free_running_counter, cnt);
	end
	// One classic Wishbone cycle, launched just after a rising edge
	task automatic bus(input logic w, input logic [3:0] a, s, input logic [31:0] d);
		int n;
		n = 0;
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, s, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) mismatches++;
		q = dat_o;
		{cyc_i, stb_i} <= 2'h0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 4'hF, 32'h0);
		check("read", q, e);
	endtask
	task automatic pulse(input logic [3:0] m);
		lv <= m;
		@(posedge clk_i);
		lv <= 4'h0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic caps;
		for (int a = 3; a < 7; a++) rd(a[3:0], {16'h0, cap[6 - a]});
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		give_verdict;
	end
	// Directed scenarios, then random pins with random modes
	initial begin
		void'($urandom(16));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		rd(4'h0, 32'h0);
		bus(1'b1, 4'hF, 4'hF, 32'hFF);
		rd(4'hF, 32'h0);
		bus(1'b1, 4'h1, 4'hF, 32'hF0);
		bus(1'b1, 4'h2, 4'hF, 32'hF0);
		pulse(4'hF);
		caps;
		bus(1'b1, 4'h0, 4'h1, 32'h0);
		rd(4'h0, {24'h0, fl, 3'h0, clr});
		bus(1'b1, 4'h0, 4'h1, 32'h70);
		bus(1'b1, 4'h1, 4'hF, 32'hFC);
		pulse(4'hF);
		caps;
		bus(1'b1, 4'h2, 4'hF, 32'h30);
		pulse(4'h3);
		bus(1'b1, 4'h2, 4'hF, 32'h0);
		rd(4'h0, {24'h0, fl, 3'h0, clr});
		lv <= 4'hF;
		bus(1'b1, 4'h0, 4'h1, 32'h0);
		lv <= 4'h0;
		bus(1'b1, 4'h8, 4'h1, $urandom_range(40, 200));
		bus(1'b1, 4'h8, 4'h2, 32'h0);
		rd(4'h8, {16'h0, cmp});
		bus(1'b1, 4'h0, 4'h1, 32'h1);
		repeat (400) @(posedge clk_i);
		bus(1'b1, 4'h1, 4'hF, $urandom);
		bus(1'b1, 4'h2, 4'hF, $urandom);
		repeat (200) begin
			lv <= $urandom;
			@(posedge clk_i);
		end
		repeat (3) @(posedge clk_i);
		caps;
		give_verdict;
	end
endmodule
bind capture_flag_status capture_flag_status_checker chk (.clk_i, .rst_i, .cyc_i, .stb_i,
	.we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .capture_pin_a_i, .capture_pin_b_i,
	.capture_pin_c_i, .capture_pin_d_i, .free_running_counter_o, .capture_flag_o, .irq_o);
